/* File: hif_pkg.sv */
// constants and types for the host interface configuration block
//
// Behaviour
// - dynamic threshold N is one third full when select is 0, one half when 1
// - dynamic priority off after reset; when on, raised while count at or below N
// - request field 00 two thirds, 01 half, 10 one third, 11 full minus two
// - shadow bit set, master and no slave present: shadow missing drive accesses
// - suspend-allow bit set lets generic-mode DMA be interrupted, else never
// - statistical priority active while disable bit is 0, off while it is 1
// - auto-off bit 0 clears fast DMA mode bit at end of transfer
// - four-bit timing value: msb from second register bit 0, rest first bits 7..5
// - auto-off bit 1 leaves fast DMA mode bit untouched at end of transfer
// - timing value adds clock cycles to ultra DMA limits; 0001 suits 33.8688 MHz
// - writing 1 to flush resets twelve-byte command pointer; 0 does nothing
// - writing 1 to clear zeroes sequencer counter and size store once only
`default_nettype none
package hif_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [15:0] HIF_ADDR_CFG_FIRST = 16'hFF94;
  localparam logic [15:0] HIF_ADDR_CFG_SECOND = 16'hFF95;
  localparam logic [7:0] HIF_CFG_FIRST_RESET = 8'h00;
  localparam logic [7:0] HIF_CFG_SECOND_RESET = 8'h00;
  // first register fields
  localparam int HIF_F_EXT_HI = 7;
  localparam int HIF_F_EXT_LO = 5;
  localparam int HIF_F_DYN_SEL = 4;
  localparam int HIF_F_DYN_EN = 3;
  localparam int HIF_F_HREQ_HI = 2;
  localparam int HIF_F_HREQ_LO = 1;
  localparam int HIF_F_SHADOW = 0;
  // second register fields
  localparam int HIF_S_DMA_SUSP = 7;
  localparam int HIF_S_STAT_OFF = 6;
  localparam int HIF_S_AUTO_OFF = 5;
  localparam int HIF_S_FLUSH = 4;
  localparam int HIF_S_SEQ_CLR = 1;
  localparam int HIF_S_EXT_MSB = 0;
  // data FIFO levels in bytes; depth is a plain default
  localparam logic [6:0] HIF_FIFO_BYTES = 7'h60;
  localparam logic [6:0] HIF_LVL_THIRD = 7'h20;
  localparam logic [6:0] HIF_LVL_HALF = 7'h30;
  localparam logic [6:0] HIF_LVL_TWO_THIRD = 7'h40;
  localparam logic [6:0] HIF_LVL_FULL_M2 = HIF_FIFO_BYTES - 7'h02;
  // request threshold encodings
  localparam logic [1:0] HIF_HREQ_TWO_THIRD = 2'h0;
  localparam logic [1:0] HIF_HREQ_HALF = 2'h1;
  localparam logic [1:0] HIF_HREQ_THIRD = 2'h2;
  localparam logic [1:0] HIF_HREQ_FULL_M2 = 2'h3;
  // command FIFO holds twelve bytes
  localparam logic [3:0] HIF_CMD_LAST = 4'hB;
  // base ultra DMA limit in clock cycles, plain default
  localparam logic [4:0] HIF_UDMA_BASE = 5'h02;
endpackage : hif_pkg
`default_nettype wire

/* File: hif_config.sv */
// host interface configuration registers and the control they steer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module hif_config
  import hif_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // data FIFO level and the priorities derived from it
  input wire logic [6:0] fifo_count,
  output logic host_req,
  output logic dyn_hi_prio,
  // statistical priority
  input wire logic stat_prio_req,
  output logic stat_hi_prio,
  // generic-mode DMA suspension
  input wire logic dma_pause_req,
  output logic dma_suspend,
  // drive configuration pins
  input wire logic is_master_pin,
  input wire logic slave_present_pin,
  output logic shadow_active,
  // transfer end and fast DMA mode bit
  input wire logic xfer_end,
  output logic fast_dma_clear,
  // command FIFO pointer and sequencer clear
  input wire logic cmd_byte_wr,
  output logic [3:0] cmd_ptr,
  output logic seq_clear,
  // ultra DMA timing
  output logic [3:0] timing_ext,
  output logic [4:0] timing_limit
);

  typedef struct packed {
    logic [7:0] cfg_first;
    logic dma_susp_en;
    logic stat_off;
    logic auto_off;
    logic ext_msb;
    logic [7:0] rdata;
    logic [2:0] sync_master;
    logic [2:0] sync_slave;
    logic master;
    logic slave;
    logic host_req;
    logic dyn_prio;
    logic stat_prio;
    logic dma_susp;
    logic shadow;
    logic fast_clr;
    logic seq_clr;
    logic [3:0] cmd_ptr;
    logic [4:0] limit;
  } hif_state_t;

  hif_state_t st;
  hif_state_t next_st;

  // maps a request code onto a byte level
  function automatic logic [6:0] hif_level(input logic [1:0] code);
    logic [6:0] lvl;
    case (code)
      HIF_HREQ_TWO_THIRD: lvl = HIF_LVL_TWO_THIRD;
      HIF_HREQ_HALF: lvl = HIF_LVL_HALF;
      HIF_HREQ_THIRD: lvl = HIF_LVL_THIRD;
      HIF_HREQ_FULL_M2: lvl = HIF_LVL_FULL_M2;
      default: lvl = HIF_LVL_TWO_THIRD;
    endcase
    return lvl;
  endfunction : hif_level

  logic wr_first;
  logic wr_second;
  logic [6:0] dyn_level;
  logic [6:0] hreq_level;
  logic [3:0] ext_now;

  assign wr_first = reg_wr && (reg_addr == HIF_ADDR_CFG_FIRST);
  assign wr_second = reg_wr && (reg_addr == HIF_ADDR_CFG_SECOND);
  // N uses the same level table as the request field
  assign dyn_level = hif_level(st.cfg_first[HIF_F_DYN_SEL] ? HIF_HREQ_HALF : HIF_HREQ_THIRD);
  assign hreq_level = hif_level(st.cfg_first[HIF_F_HREQ_HI:HIF_F_HREQ_LO]);
  assign ext_now = {st.ext_msb, st.cfg_first[HIF_F_EXT_HI:HIF_F_EXT_LO]};

  always_comb begin
    next_st = st;
    // register writes
    if (wr_first) begin
      next_st.cfg_first = reg_wdata;
    end
    if (wr_second) begin
      next_st.dma_susp_en = reg_wdata[HIF_S_DMA_SUSP];
      next_st.stat_off = reg_wdata[HIF_S_STAT_OFF];
      next_st.auto_off = reg_wdata[HIF_S_AUTO_OFF];
      next_st.ext_msb = reg_wdata[HIF_S_EXT_MSB];
    end
    // reads answer one cycle later; unmapped reads return zero
    next_st.rdata = 8'h00;
    if (reg_rd && reg_addr == HIF_ADDR_CFG_FIRST) begin
      next_st.rdata = st.cfg_first;
    end else if (reg_rd && reg_addr == HIF_ADDR_CFG_SECOND) begin
      // flush and clear are strobes and always read back as zero
      next_st.rdata = {st.dma_susp_en, st.stat_off, st.auto_off, 4'h0, st.ext_msb};
    end
    // pins cross three stages; a level counts once stages two and three agree
    next_st.sync_master = {st.sync_master[1:0], is_master_pin};
    next_st.sync_slave = {st.sync_slave[1:0], slave_present_pin};
    if (st.sync_master[1] == st.sync_master[2]) begin
      next_st.master = st.sync_master[2];
    end
    if (st.sync_slave[1] == st.sync_slave[2]) begin
      next_st.slave = st.sync_slave[2];
    end
    // FIFO thresholds
    next_st.host_req = (fifo_count >= hreq_level);
    next_st.dyn_prio = st.cfg_first[HIF_F_DYN_EN] && (fifo_count <= dyn_level);
    next_st.stat_prio = stat_prio_req && !st.stat_off;
    next_st.dma_susp = dma_pause_req && st.dma_susp_en;
    next_st.shadow = st.cfg_first[HIF_F_SHADOW] && st.master && !st.slave;
    // end of transfer: clear the fast DMA mode bit only when auto-off is 0
    next_st.fast_clr = xfer_end && !st.auto_off;
    // sequencer clear is a single pulse per write of 1
    next_st.seq_clr = wr_second && reg_wdata[HIF_S_SEQ_CLR];
    // command pointer: flush beats a byte arriving in the same cycle
    if (wr_second && reg_wdata[HIF_S_FLUSH]) begin
      next_st.cmd_ptr = 4'h0;
    end else if (cmd_byte_wr && st.cmd_ptr != HIF_CMD_LAST) begin
      next_st.cmd_ptr = st.cmd_ptr + 4'h1;
    end
    // extension widens the ultra DMA limits; tracks the registers a cycle late
    next_st.limit = HIF_UDMA_BASE + {1'b0, ext_now};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cfg_first <= HIF_CFG_FIRST_RESET;
      st.dma_susp_en <= HIF_CFG_SECOND_RESET[HIF_S_DMA_SUSP];
      st.stat_off <= HIF_CFG_SECOND_RESET[HIF_S_STAT_OFF];
      st.auto_off <= HIF_CFG_SECOND_RESET[HIF_S_AUTO_OFF];
      st.ext_msb <= HIF_CFG_SECOND_RESET[HIF_S_EXT_MSB];
      st.limit <= HIF_UDMA_BASE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign host_req = st.host_req;
  assign dyn_hi_prio = st.dyn_prio;
  assign stat_hi_prio = st.stat_prio;
  assign dma_suspend = st.dma_susp;
  assign shadow_active = st.shadow;
  assign fast_dma_clear = st.fast_clr;
  assign cmd_ptr = st.cmd_ptr;
  assign seq_clear = st.seq_clr;
  assign timing_ext = ext_now;
  assign timing_limit = st.limit;

  default clocking hif_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_dyn_sel_level: assert property (
    (st.cfg_first[HIF_F_DYN_EN] && st.cfg_first[HIF_F_DYN_SEL] && fifo_count == HIF_LVL_HALF)
      |=> dyn_hi_prio)
    else $error("dynamic priority missing at half level");

  a_dyn_prio_off: assert property (
    (!st.cfg_first[HIF_F_DYN_EN] || fifo_count > dyn_level) |=> !dyn_hi_prio)
    else $error("dynamic priority raised when off or above level");

  a_hreq_level: assert property (
    1'b1 |=> host_req == $past(fifo_count >= hreq_level))
    else $error("host request does not match threshold");

  a_shadow_cond: assert property (
    shadow_active |-> $past(st.cfg_first[HIF_F_SHADOW] && st.master && !st.slave))
    else $error("shadowing without master alone and enable");

  a_dma_suspend: assert property (
    (dma_pause_req && !st.dma_susp_en) |=> !dma_suspend)
    else $error("generic DMA suspended while not allowed");

  a_stat_prio: assert property (
    stat_prio_req |=> stat_hi_prio == !$past(st.stat_off))
    else $error("statistical priority ignores disable bit");

  a_fast_clear: assert property (
    (xfer_end && !st.auto_off) |=> fast_dma_clear ##1 (fast_dma_clear == $past(xfer_end)))
    else $error("fast DMA bit not cleared at transfer end");

  a_fast_keep: assert property (
    fast_dma_clear |-> $past(xfer_end) && !$past(st.auto_off))
    else $error("fast DMA bit cleared without cause");

  a_ext_msb: assert property (
    (wr_second && !wr_first) |=> timing_ext[3] == $past(reg_wdata[HIF_S_EXT_MSB]))
    else $error("timing msb not taken from second register");

  a_limit_add: assert property (
    1'b1 |=> timing_limit == HIF_UDMA_BASE + {1'b0, $past(timing_ext)})
    else $error("ultra limit not extended by timing value");

  a_flush_ptr: assert property (
    (wr_second && reg_wdata[HIF_S_FLUSH]) |=> cmd_ptr == 4'h0)
    else $error("command pointer not flushed");

  a_seq_once: assert property (
    seq_clear |-> $past(wr_second && reg_wdata[HIF_S_SEQ_CLR]))
    else $error("sequencer clear without a write of one");

  a_dyn_third_level: assert property (
    (st.cfg_first[HIF_F_DYN_EN] && !st.cfg_first[HIF_F_DYN_SEL] && fifo_count == HIF_LVL_THIRD)
      |=> dyn_hi_prio)
    else $error("dynamic priority missing at third level");

  a_dyn_half_above: assert property (
    (st.cfg_first[HIF_F_DYN_EN] && st.cfg_first[HIF_F_DYN_SEL] && fifo_count > HIF_LVL_HALF)
      |=> !dyn_hi_prio)
    else $error("dynamic priority raised above half level");

  a_dyn_prio_on: assert property (
    (st.cfg_first[HIF_F_DYN_EN] && fifo_count <= dyn_level) |=> dyn_hi_prio)
    else $error("dynamic priority missing at or below level");

  a_hreq_two_third: assert property (
    (st.cfg_first[HIF_F_HREQ_HI:HIF_F_HREQ_LO] == HIF_HREQ_TWO_THIRD
      && fifo_count == HIF_LVL_TWO_THIRD) |=> host_req)
    else $error("host request missing at two thirds");

  a_hreq_full_m2: assert property (
    (st.cfg_first[HIF_F_HREQ_HI:HIF_F_HREQ_LO] == HIF_HREQ_FULL_M2
      && fifo_count < HIF_LVL_FULL_M2) |=> !host_req)
    else $error("host request raised below full minus two");

  a_shadow_on: assert property (
    (st.cfg_first[HIF_F_SHADOW] && st.master && !st.slave) |=> shadow_active)
    else $error("shadowing missing for lone master");

  a_shadow_off: assert property (
    !st.cfg_first[HIF_F_SHADOW] |=> !shadow_active)
    else $error("shadowing active while disabled");

  a_dma_allow: assert property (
    (dma_pause_req && st.dma_susp_en) |=> dma_suspend)
    else $error("generic DMA not suspended while allowed");

  a_dma_no_req: assert property (
    !dma_pause_req |=> !dma_suspend)
    else $error("generic DMA suspended without a request");

  a_stat_off: assert property (
    st.stat_off |=> !stat_hi_prio)
    else $error("statistical priority raised while disabled");

  a_fast_pulse: assert property (
    1'b1 |=> fast_dma_clear == $past(xfer_end && !st.auto_off))
    else $error("fast DMA clear pulse does not follow transfer end");

  a_fast_auto_on: assert property (
    st.auto_off |=> !fast_dma_clear)
    else $error("fast DMA bit cleared while auto-off is set");

  a_ext_low: assert property (
    wr_first |=> timing_ext[2:0] == $past(reg_wdata[HIF_F_EXT_HI:HIF_F_EXT_LO]))
    else $error("timing low bits not taken from first register");

  a_ext_hold: assert property (
    !(wr_first || wr_second) |=> $stable(timing_ext))
    else $error("timing value moved without a register write");

  a_flush_zero: assert property (
    (wr_second && !reg_wdata[HIF_S_FLUSH] && !cmd_byte_wr) |=> $stable(cmd_ptr))
    else $error("command pointer moved on a write of zero");

  a_ptr_step: assert property (
    (cmd_byte_wr && cmd_ptr != HIF_CMD_LAST && !(wr_second && reg_wdata[HIF_S_FLUSH]))
      |=> cmd_ptr == $past(cmd_ptr) + 4'h1)
    else $error("command pointer did not step");

  a_ptr_hold_last: assert property (
    (cmd_ptr == HIF_CMD_LAST && !(wr_second && reg_wdata[HIF_S_FLUSH]))
      |=> cmd_ptr == HIF_CMD_LAST)
    else $error("command pointer left its last slot");

  a_seq_pulse: assert property (
    (wr_second && reg_wdata[HIF_S_SEQ_CLR]) |=> seq_clear)
    else $error("sequencer clear missing after a write of one");

  a_seq_zero: assert property (
    (wr_second && !reg_wdata[HIF_S_SEQ_CLR]) |=> !seq_clear)
    else $error("sequencer clear after a write of zero");

  a_read_first: assert property (
    (reg_rd && reg_addr == HIF_ADDR_CFG_FIRST) |=> reg_rdata == $past(st.cfg_first))
    else $error("first register read back wrong");

  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present without a read");

  c_dyn_prio: cover property (dyn_hi_prio ##1 !dyn_hi_prio);
  c_shadow: cover property (shadow_active);
  c_flush_full: cover property (cmd_ptr == HIF_CMD_LAST ##1 cmd_ptr == 4'h0);
  c_fast_clear: cover property (fast_dma_clear);

endmodule : hif_config
`default_nettype wire

/* File: hif_xfer_model.sv */
// far-side transfer engine model holding the fast DMA mode bit
`timescale 1ns/1ns
`default_nettype none
module hif_xfer_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // start a transfer, clear request from the block
  input wire logic go,
  input wire logic fast_dma_clear,
  // end pulse and mode bit of transfer_control_reg
  output logic xfer_end,
  output logic fast_mode
);
  logic [1:0] cnt;
  // end pulse comes three cycles after go so the block sees a real transfer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      xfer_end <= 1'b0;
      fast_mode <= 1'b0;
    end else begin
      xfer_end <= (cnt == 2'h1);
      cnt <= go ? 2'h3 : ((cnt != 2'h0) ? cnt - 2'h1 : 2'h0);
      if (go) begin
        fast_mode <= 1'b1;
      end else if (fast_dma_clear) begin
        fast_mode <= 1'b0;
      end
    end
  end
endmodule : hif_xfer_model
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hif_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, rd;
  logic [6:0] fifo_count = 7'h00;
  logic stat_prio_req = 0, dma_pause_req = 0, is_master_pin = 0, slave_present_pin = 0;
  logic cmd_byte_wr = 0, host_req, dyn_hi_prio, stat_hi_prio, dma_suspend, shadow_active;
  logic xfer_end, fast_dma_clear, seq_clear, fast_mode;
  logic [7:0] reg_rdata;
  logic [3:0] cmd_ptr, timing_ext;
  logic [4:0] timing_limit;
  logic [6:0] lvl [4] = '{HIF_LVL_TWO_THIRD, HIF_LVL_HALF, HIF_LVL_THIRD, HIF_LVL_FULL_M2};
  int failures = 0, comparisons = 0;
  hif_config uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_count(fifo_count), .host_req(host_req), .dyn_hi_prio(dyn_hi_prio),
    .stat_prio_req(stat_prio_req), .stat_hi_prio(stat_hi_prio), .dma_pause_req(dma_pause_req),
    .dma_suspend(dma_suspend), .is_master_pin(is_master_pin),
    .slave_present_pin(slave_present_pin), .shadow_active(shadow_active), .xfer_end(xfer_end),
    .fast_dma_clear(fast_dma_clear), .cmd_byte_wr(cmd_byte_wr), .cmd_ptr(cmd_ptr),
    .seq_clear(seq_clear), .timing_ext(timing_ext), .timing_limit(timing_limit));
  hif_xfer_model model (.core_clk(core_clk), .rst_n(rst_n), .go(go),
    .fast_dma_clear(fast_dma_clear), .xfer_end(xfer_end), .fast_mode(fast_mode));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd_reg(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg
  task fifo(input logic [6:0] v);
    @(posedge core_clk);
    fifo_count <= v;
    @(posedge core_clk);
    #1;
  endtask : fifo
  task t_regs;
    rd_reg(HIF_ADDR_CFG_FIRST); chk("first reset", HIF_CFG_FIRST_RESET, rd);
    rd_reg(HIF_ADDR_CFG_SECOND); chk("second reset", HIF_CFG_SECOND_RESET, rd);
    wr(HIF_ADDR_CFG_FIRST, 8'hA5); rd_reg(HIF_ADDR_CFG_FIRST); chk("first rw", 8'hA5, rd);
    wr(16'hFF97, 8'hFF); rd_reg(16'hFF97); chk("unmapped", 8'h00, rd);
    wr(HIF_ADDR_CFG_FIRST, 8'hE0); wr(HIF_ADDR_CFG_SECOND, 8'h01);
    @(posedge core_clk); #1;
    chk("timing ext", 8'h0F, {4'h0, timing_ext});
    chk("timing limit", {3'h0, 5'(HIF_UDMA_BASE + 5'h0F)}, {3'h0, timing_limit});
    rd_reg(HIF_ADDR_CFG_SECOND); chk("second rw", 8'h01, rd);
    $display("test regs done");
  endtask : t_regs
  task t_thresh;
    for (int c = 0; c < 4; c++) begin
      wr(HIF_ADDR_CFG_FIRST, 8'(c << 1));
      fifo(lvl[c] - 7'h01); chk("hreq below", 8'h00, {7'h0, host_req});
      fifo(lvl[c]); chk("hreq at", 8'h01, {7'h0, host_req});
    end
    fifo(7'h00); chk("dyn off", 8'h00, {7'h0, dyn_hi_prio});
    for (int s = 0; s < 2; s++) begin
      wr(HIF_ADDR_CFG_FIRST, s ? 8'h18 : 8'h08);
      fifo(s ? HIF_LVL_HALF : HIF_LVL_THIRD); chk("dyn at n", 8'h01, {7'h0, dyn_hi_prio});
      fifo(s ? 7'h31 : 7'h21); chk("dyn above n", 8'h00, {7'h0, dyn_hi_prio});
    end
    $display("test thresholds done");
  endtask : t_thresh
  task t_ctrl;
    @(posedge core_clk);
    stat_prio_req <= 1'b1;
    dma_pause_req <= 1'b1;
    wr(HIF_ADDR_CFG_SECOND, 8'h00); @(posedge core_clk); #1;
    chk("stat dma on", 8'h02, {6'h0, stat_hi_prio, dma_suspend});
    wr(HIF_ADDR_CFG_SECOND, 8'hC0); @(posedge core_clk); #1;
    chk("stat dma off", 8'h01, {6'h0, stat_hi_prio, dma_suspend});
    wr(HIF_ADDR_CFG_FIRST, 8'h01);
    is_master_pin <= 1'b1;
    repeat (8) @(posedge core_clk); #1;
    chk("shadow on", 8'h01, {7'h0, shadow_active});
    @(posedge core_clk); slave_present_pin <= 1'b1;
    repeat (8) @(posedge core_clk); #1;
    chk("shadow slave", 8'h00, {7'h0, shadow_active});
    wr(HIF_ADDR_CFG_FIRST, 8'h00); @(posedge core_clk); slave_present_pin <= 1'b0;
    repeat (8) @(posedge core_clk); #1;
    chk("shadow off", 8'h00, {7'h0, shadow_active});
    $display("test control done");
  endtask : t_ctrl
  task t_xfer(input logic [7:0] cfg, input logic [7:0] exp);
    wr(HIF_ADDR_CFG_SECOND, cfg);
    go <= 1'b1;
    @(posedge core_clk); go <= 1'b0;
    repeat (8) @(posedge core_clk); #1;
    chk("fast mode", exp, {7'h0, fast_mode});
    $display("test transfer done");
  endtask : t_xfer
  task t_cmd;
    @(posedge core_clk); cmd_byte_wr <= 1'b1;
    repeat (14) @(posedge core_clk);
    cmd_byte_wr <= 1'b0; #1;
    chk("cmd sat", 8'h0B, {4'h0, cmd_ptr});
    wr(HIF_ADDR_CFG_SECOND, 8'h00); #1;
    chk("flush zero", 8'h0B, {seq_clear, 3'h0, cmd_ptr});
    wr(HIF_ADDR_CFG_SECOND, 8'h12); #1;
    chk("flush one", 8'h80, {seq_clear, 3'h0, cmd_ptr});
    @(posedge core_clk); #1; chk("clear once", 8'h00, {7'h0, seq_clear});
    $display("test command done");
  endtask : t_cmd
  task finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_thresh();
    t_ctrl();
    t_xfer(8'h00, 8'h00);
    t_xfer(8'h20, 8'h01);
    t_cmd();
    finish_test();
  end
endmodule : tb
`default_nettype wire
